/* File: rtcdc_pkg.sv */
package rtcdc_pkg;
    // Register offsets on the device's control interface
    localparam logic [7:0] OFS_COMP_LOW   = 8'h13;
    localparam logic [7:0] OFS_COMP_HIGH  = 8'h14;
    localparam logic [7:0] OFS_TRIM       = 8'h15;
    localparam logic [7:0] OFS_INTACT     = 8'h16;
    localparam logic [7:0] OFS_SCRATCH    = 8'h17;
    // Reset values and the forbidden compensation code
    localparam logic [7:0] RST_COMP       = 8'h00;
    localparam logic [5:0] RST_TRIM       = 6'h27;
    localparam logic [7:0] RST_SCRATCH    = 8'h00;
    localparam logic [15:0] COMP_FORBIDDEN = 16'h7fff;
    // Host's own APB register word addresses
    localparam logic [11:0] APB_CMD       = 12'h000;
    localparam logic [11:0] APB_STATUS    = 12'h004;
    localparam logic [11:0] APB_RDATA     = 12'h008;
    // Command word fields
    localparam int CMD_WDATA_LSB = 0;
    localparam int CMD_ADDR_LSB  = 8;
    localparam int CMD_WRITE_BIT = 16;
    // Hour tick period in device clocks: 3600 s at 10 MHz
    localparam longint HOUR_S       = 3600;
    localparam longint CLK_HZ       = 10000000;
    localparam longint HOUR_CYCLES  = HOUR_S * CLK_HZ;
endpackage

/* File: rtcdc_if.sv */
`timescale 1ns/10ps
interface rtcdc_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    modport dev  (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

/* File: rtcdc_device.sv */
`timescale 1ns/10ps
// How it works
// - Host writes signed compensation across two bytes.
// - Hourly adjust by signed high:low periods.
// - All ones inserts one extra period.
// - Value one drops one period.
// - Host never loads 7fff.
// - Compensation bytes read-write, reset zero.
// - Six-bit trim, reset 0x27, drives oscillator.
// - Intact flag set-only by write one.
// - Manual reset or POR clears intact flag.
// - Host reprograms after cleared intact flag; rtcdc_host never reads the flag and leaves this to software.
// - Scratch byte read-write, reset zero, retained.
// - Defaults only on full reset, except the intact flag.
module rtcdc_device
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Lighter reset and clear causes
    input  wire logic         manual_rst,
    input  wire logic         por_low_batt,
    // Hour tick from the time counter
    input  wire logic         hour_tick,
    // Control side
    rtcdc_if.dev              bus,
    // Oscillator and counter controls
    output logic       [5:0]  osc_resistance_value,
    output logic signed [15:0] period_adjust,
    output logic              adjust_pulse
);
    logic [7:0]  comp_low_r;
    logic [7:0]  comp_high_r;
    logic [15:0] comp_active_r;
    logic        low_seen_r;
    logic        high_seen_r;
    logic [5:0]  trim_r;
    logic        intact_r;
    logic [7:0]  scratch_r;
    logic        ack_r;
    logic [7:0]  rdata_r;
    logic        wr_go;
    logic        mr_s1;
    logic        mr_s2;
    logic        por_s1;
    logic        por_s2;
    logic        wr_low;
    logic        wr_high;
    logic        wr_trim;
    logic        wr_intact;
    logic        wr_scratch;
    logic        pair_done;
    logic        clr_cause;
    logic [7:0]  rd_mux;

    assign wr_go      = bus.req & bus.wr & ~ack_r;

    // One strobe per register keeps each update process small
    assign wr_low     = wr_go & (bus.addr == rtcdc_pkg::OFS_COMP_LOW);
    assign wr_high    = wr_go & (bus.addr == rtcdc_pkg::OFS_COMP_HIGH);
    assign wr_trim    = wr_go & (bus.addr == rtcdc_pkg::OFS_TRIM);
    assign wr_intact  = wr_go & (bus.addr == rtcdc_pkg::OFS_INTACT);
    assign wr_scratch = wr_go & (bus.addr == rtcdc_pkg::OFS_SCRATCH);
    assign pair_done  = low_seen_r & high_seen_r;
    assign clr_cause  = mr_s2 | por_s2;

    // Clear causes come from pins, so synchronise
    always_ff @(posedge sys_clk)
    begin
        mr_s1 <= manual_rst;
        mr_s2 <= mr_s1;
    end

    // Battery monitor is another domain as well
    always_ff @(posedge sys_clk)
    begin
        por_s1 <= por_low_batt;
        por_s2 <= por_s1;
    end

    // Only the full reset restores these; lighter resets leave them alone
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            comp_low_r <= rtcdc_pkg::RST_COMP;
        else if (wr_low)
            comp_low_r <= bus.wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            comp_high_r <= rtcdc_pkg::RST_COMP;
        else if (wr_high)
            comp_high_r <= bus.wdata;
    end

    // Only six bits are stored; the reserved pair falls away
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            trim_r <= rtcdc_pkg::RST_TRIM;
        else if (wr_trim)
            trim_r <= bus.wdata[5:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            scratch_r <= rtcdc_pkg::RST_SCRATCH;
        else if (wr_scratch)
            scratch_r <= bus.wdata;
    end

    // Clear wins only from reset causes; a write of zero is ignored
    always_ff @(posedge sys_clk)
    begin
        if (rst || clr_cause)
            intact_r <= 1'b0;
        else if (wr_intact && bus.wdata[0])
            intact_r <= 1'b1;
    end

    // A write landing in the apply cycle is kept for the next pair
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            low_seen_r  <= 1'b0;
            high_seen_r <= 1'b0;
        end
        else
        begin
            low_seen_r  <= wr_low | (low_seen_r & ~pair_done);
            high_seen_r <= wr_high | (high_seen_r & ~pair_done);
        end
    end

    // Both halves must land before the pair is used
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            comp_active_r <= {rtcdc_pkg::RST_COMP, rtcdc_pkg::RST_COMP};
        else if (pair_done)
            comp_active_r <= {comp_high_r, comp_low_r};
    end

    // Pulse marks the hour on which period_adjust is fresh
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            adjust_pulse <= 1'b0;
        else
            adjust_pulse <= hour_tick;
    end

    // Positive value drops periods, so negate: ffff gives +1, 0001 gives -1
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            period_adjust <= 16'sh0000;
        else if (hour_tick)
            period_adjust <= 16'sh0000 - $signed(comp_active_r);
    end

    // Oscillator follows the stored trim one cycle later
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            osc_resistance_value <= rtcdc_pkg::RST_TRIM;
        else
            osc_resistance_value <= trim_r;
    end

    // Reserved bits and unmapped offsets read as zero
    always_comb
    begin
        unique case (bus.addr)
            rtcdc_pkg::OFS_COMP_LOW:  rd_mux = comp_low_r;
            rtcdc_pkg::OFS_COMP_HIGH: rd_mux = comp_high_r;
            rtcdc_pkg::OFS_TRIM:      rd_mux = {2'b00, trim_r};
            rtcdc_pkg::OFS_INTACT:    rd_mux = {7'h00, intact_r};
            rtcdc_pkg::OFS_SCRATCH:   rd_mux = scratch_r;
            default:                  rd_mux = 8'h00;
        endcase
    end

    // One-cycle acknowledge; host drops req after seeing it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= bus.req & ~ack_r;
    end

    // Read data is held until the next request is taken
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (bus.req && !ack_r)
            rdata_r <= rd_mux;
    end

    assign bus.ack   = ack_r;
    assign bus.rdata = rdata_r;
endmodule // rtcdc_device

/* File: rtcdc_host.sv */
`timescale 1ns/10ps
module rtcdc_host
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // Device side
    rtcdc_if.host             dev
);
    typedef enum {ST_IDLE, ST_WAIT, ST_DROP} rtcdc_st_t;
    rtcdc_st_t   st_r;
    logic        req_r;
    logic        wr_r;
    logic [7:0]  addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rd_r;
    logic        busy;
    logic        forbid_r;
    logic        hi_fbd_r;
    logic        apb_go;
    logic        cmd_wr;
    logic        ok_cmd;

    assign busy   = (st_r != ST_IDLE);
    assign apb_go = psel & penable & ~pready;
    assign cmd_wr = apb_go & pwrite & (paddr == rtcdc_pkg::APB_CMD);
    // Refuse either half that would complete 7fff, whichever order software uses
    assign ok_cmd = !(pwdata[rtcdc_pkg::CMD_WRITE_BIT]
                      && ((pwdata[rtcdc_pkg::CMD_ADDR_LSB +: 8] == rtcdc_pkg::OFS_COMP_HIGH
                           && pwdata[rtcdc_pkg::CMD_WDATA_LSB +: 8] == rtcdc_pkg::COMP_FORBIDDEN[15:8]
                           && forbid_r)
                          || (pwdata[rtcdc_pkg::CMD_ADDR_LSB +: 8] == rtcdc_pkg::OFS_COMP_LOW
                              && pwdata[rtcdc_pkg::CMD_WDATA_LSB +: 8] == rtcdc_pkg::COMP_FORBIDDEN[7:0]
                              && hi_fbd_r)));

    // Remember whether last accepted low byte was ff
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            forbid_r <= 1'b0;
        else if (cmd_wr && !busy && ok_cmd && pwdata[rtcdc_pkg::CMD_WRITE_BIT]
                 && pwdata[rtcdc_pkg::CMD_ADDR_LSB +: 8] == rtcdc_pkg::OFS_COMP_LOW)
            forbid_r <= (pwdata[7:0] == rtcdc_pkg::COMP_FORBIDDEN[7:0]);
    end

    // Remember whether last accepted high byte was 7f
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            hi_fbd_r <= 1'b0;
        else if (cmd_wr && !busy && ok_cmd && pwdata[rtcdc_pkg::CMD_WRITE_BIT]
                 && pwdata[rtcdc_pkg::CMD_ADDR_LSB +: 8] == rtcdc_pkg::OFS_COMP_HIGH)
            hi_fbd_r <= (pwdata[rtcdc_pkg::CMD_WDATA_LSB +: 8] == rtcdc_pkg::COMP_FORBIDDEN[15:8]);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_go;
            pslverr <= cmd_wr & (busy | ~ok_cmd);
            if (apb_go && !pwrite)
            begin
                unique case (paddr)
                    rtcdc_pkg::APB_STATUS: prdata <= {31'h0, busy};
                    rtcdc_pkg::APB_RDATA:  prdata <= {24'h0, rd_r};
                    default:               prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // One device transaction per command; both bytes sent by software
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r    <= ST_IDLE;
            req_r   <= 1'b0;
            wr_r    <= 1'b0;
            addr_r  <= 8'h00;
            wdata_r <= 8'h00;
            rd_r    <= 8'h00;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                    if (cmd_wr && ok_cmd)
                    begin
                        req_r   <= 1'b1;
                        wr_r    <= pwdata[rtcdc_pkg::CMD_WRITE_BIT];
                        addr_r  <= pwdata[rtcdc_pkg::CMD_ADDR_LSB +: 8];
                        wdata_r <= pwdata[rtcdc_pkg::CMD_WDATA_LSB +: 8];
                        st_r    <= ST_WAIT;
                    end
                ST_WAIT:
                    if (dev.ack)
                    begin
                        req_r <= 1'b0;
                        rd_r  <= dev.rdata;
                        st_r  <= ST_DROP;
                    end
                ST_DROP:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    assign dev.req   = req_r;
    assign dev.wr    = wr_r;
    assign dev.addr  = addr_r;
    assign dev.wdata = wdata_r;
endmodule // rtcdc_host

/* File: rtcdc_asserts.sv */
`timescale 1ns/10ps
module rtcdc_asserts
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Device link
    input wire logic       req,
    input wire logic       wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    logic [7:0] shd_r [0:7];
    logic       rw_hit;
    assign rw_hit = addr inside {rtcdc_pkg::OFS_COMP_LOW, rtcdc_pkg::OFS_COMP_HIGH, rtcdc_pkg::OFS_SCRATCH};

    // Shadow of the plain read-write bytes, cleared by the full reset only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 8; i++)
            begin
                shd_r[i] <= 8'h00;
            end
        end
        else if (ack && wr && rw_hit)
        begin
            shd_r[addr[2:0]] <= wdata;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_idle2;
        !req ##1 !req;
    endsequence

    AST_ACK_AFTER_REQ: assert property (req && !ack |=> ack)
        else $error("request not answered");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> req)
        else $error("ack without request");
    AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("request changed before ack");
    AST_REQ_IDLE: assert property (ack |=> s_idle2)
        else $error("host did not idle after ack");
    AST_RW_READ: assert property (ack && !wr && rw_hit |-> rdata == shd_r[addr[2:0]])
        else $error("read-write byte read back wrong");
    AST_TRIM_RSV: assert property (ack && !wr && addr == rtcdc_pkg::OFS_TRIM |-> rdata[7:6] == 2'b00)
        else $error("trim reserved bits not zero");
    AST_FLAG_RSV: assert property (ack && !wr && addr == rtcdc_pkg::OFS_INTACT |-> rdata[7:1] == 7'h00)
        else $error("flag reserved bits not zero");
    AST_UNMAPPED: assert property (ack && !wr && !(addr inside {[8'h13:8'h17]}) |-> rdata == 8'h00)
        else $error("unmapped offset read not zero");
endmodule // rtcdc_asserts

/* File: rtcdc_tb_top.sv */
`timescale 1ns/10ps
module rtcdc_tb_top;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               manual_rst = 1'b0;
    logic               por_low_batt = 1'b0;
    logic               hour_tick = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [5:0]         osc_resistance_value;
    logic signed [15:0] period_adjust;
    logic               adjust_pulse;
    logic [31:0]        q;
    logic               serr;
    logic               cmd_err;
    logic [7:0]         rst_val [0:4] = '{8'h00, 8'h00, 8'h27, 8'h00, 8'h00};
    int                 err_total = 0;
    int                 n_compared = 0;

    always #50 sys_clk = ~sys_clk;

    rtcdc_if i_rtcdc_if ();
    rtcdc_device i_rtcdc_device (.sys_clk(sys_clk), .rst(rst), .manual_rst(manual_rst), .por_low_batt(por_low_batt),
        .hour_tick(hour_tick), .bus(i_rtcdc_if), .osc_resistance_value(osc_resistance_value),
        .period_adjust(period_adjust), .adjust_pulse(adjust_pulse));
    rtcdc_host i_rtcdc_host (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev(i_rtcdc_if));
    rtcdc_asserts i_rtcdc_asserts (.sys_clk(sys_clk), .rst(rst), .req(i_rtcdc_if.req), .wr(i_rtcdc_if.wr),
        .addr(i_rtcdc_if.addr), .wdata(i_rtcdc_if.wdata), .ack(i_rtcdc_if.ack), .rdata(i_rtcdc_if.rdata));

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_total++;
            complete_run();
        end
    endtask

    // Command, wait while busy, then fetch the last device read data
    task automatic dev_op(input logic w, input logic [7:0] off, input logic [7:0] d);
        int n;
        apb(1'b1, rtcdc_pkg::APB_CMD, {15'h0000, w, off, d});
        cmd_err = serr;
        n = 0;
        do
        begin
            apb(1'b0, rtcdc_pkg::APB_STATUS, 32'h0);
            n++;
        end
        while (q[0] !== 1'b0 && n < 20);
        if (q[0] !== 1'b0)
        begin
            err_total++;
            complete_run();
        end
        apb(1'b0, rtcdc_pkg::APB_RDATA, 32'h0);
    endtask

    task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
        dev_op(1'b0, off, 8'h00);
        chk(q, {24'h0, exp});
    endtask

    task automatic hour(input logic [15:0] exp);
        @(posedge sys_clk);
        hour_tick <= 1'b1;
        @(posedge sys_clk);
        hour_tick <= 1'b0;
        @(posedge sys_clk);
        chk({31'h0, adjust_pulse}, 32'h1);
        chk({16'h0, period_adjust}, {16'h0, exp});
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rdc(rtcdc_pkg::OFS_COMP_LOW + 8'(i), rst_val[i]);
        end
        chk({26'h0, osc_resistance_value}, {26'h0, rtcdc_pkg::RST_TRIM});
        chk({16'h0, period_adjust}, 32'h0);
        rdc(8'h20, 8'h00);
        dev_op(1'b1, rtcdc_pkg::OFS_SCRATCH, 8'ha5);
        rdc(rtcdc_pkg::OFS_SCRATCH, 8'ha5);
        dev_op(1'b1, rtcdc_pkg::OFS_TRIM, 8'hff);
        rdc(rtcdc_pkg::OFS_TRIM, 8'h3f);
        chk({26'h0, osc_resistance_value}, 32'h3f);
        dev_op(1'b1, rtcdc_pkg::OFS_INTACT, 8'hfe);
        rdc(rtcdc_pkg::OFS_INTACT, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            dev_op(1'b1, rtcdc_pkg::OFS_INTACT, 8'h01);
            dev_op(1'b1, rtcdc_pkg::OFS_INTACT, 8'h00);
            rdc(rtcdc_pkg::OFS_INTACT, 8'h01);
            manual_rst <= (k == 0);
            por_low_batt <= (k == 1);
            repeat (4) @(posedge sys_clk);
            manual_rst <= 1'b0;
            por_low_batt <= 1'b0;
            rdc(rtcdc_pkg::OFS_INTACT, 8'h00);
            rdc(rtcdc_pkg::OFS_SCRATCH, 8'ha5);
            rdc(rtcdc_pkg::OFS_TRIM, 8'h3f);
        end
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_LOW, 8'hff);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_HIGH, 8'hff);
        chk({31'h0, cmd_err}, 32'h0);
        hour(16'h0001);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_LOW, 8'h01);
        hour(16'h0001);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_HIGH, 8'h00);
        hour(16'hffff);
        // Forbidden code must be refused and leave the applied value alone
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_LOW, 8'hff);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_HIGH, 8'h7f);
        chk({31'h0, cmd_err}, 32'h1);
        rdc(rtcdc_pkg::OFS_COMP_HIGH, 8'h00);
        hour(16'hffff);
        // Reverse order: high 7f first, then low ff must be refused
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_LOW, 8'h00);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_HIGH, 8'h7f);
        chk({31'h0, cmd_err}, 32'h0);
        dev_op(1'b1, rtcdc_pkg::OFS_COMP_LOW, 8'hff);
        chk({31'h0, cmd_err}, 32'h1);
        hour(16'h8100);
        // Full reset in mid-run brings every default back
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(rtcdc_pkg::OFS_SCRATCH, rtcdc_pkg::RST_SCRATCH);
        rdc(rtcdc_pkg::OFS_COMP_LOW, rtcdc_pkg::RST_COMP);
        chk({26'h0, osc_resistance_value}, {26'h0, rtcdc_pkg::RST_TRIM});
        hour(16'h0000);
        complete_run();
    end
endmodule // rtcdc_tb_top
